// >>> shared/i2csw_consts.vh
// constants for the i2c switch control slave
// Notes on behaviour
// - reset pin held low clears control register and serial state machine.
// - power-on reset leaves the control register zero, all channels deselected.
// - one data bit per clock pulse; data stays stable while clock high.
// - idle bus rests with both clock and data high.
// - receiver acknowledges by holding data low through ninth clock high phase.
// - not-acknowledge leaves data released high through ninth clock pulse.
// - first byte after START is seven address bits msb first, then direction.
// - address byte lsb is direction: 0 write control byte, 1 read it.
// - idle device waits for START plus own address before moving data.
// - on address match device pulls data low for one clock pulse.
// - address is fixed prefix plus pin bits: 11100+2 pins or 1110+3 pins.
// - write keeps low 4 (switch) or 3 (mux) bits; last byte wins.
// - written selection takes effect only at the STOP ending the write.
// - read returns live channel alert levels in bits 4 to 7, 1 means alert.
`ifndef I2CSW_CONSTS_VH
`define I2CSW_CONSTS_VH
`define I2CSW_PREFIX5 5'h1C
`define I2CSW_PREFIX4 4'hE
`define I2CSW_ST_IDLE 3'h0
`define I2CSW_ST_ADDR 3'h1
`define I2CSW_ST_AACK 3'h2
`define I2CSW_ST_WDAT 3'h3
`define I2CSW_ST_WACK 3'h4
`define I2CSW_ST_RDAT 3'h5
`define I2CSW_ST_RACK 3'h6
`define I2CSW_SEL_RESET 4'h0
// pin synchroniser reset levels: alerts idle high in bits 3:0, address pins low in 6:4
`define I2CSW_PIN_RESET 7'h0F
`endif

// >>> design/i2csw_slave.v
// serial control slave of the four channel bus switch / multiplexer
`timescale 1ns/100ps
`include "i2csw_consts.vh"
module i2csw_slave #(
  parameter MUX_VARIANT = 0 // 0: switch 11100+2 pins, 1: mux 1110+3 pins
) (
  input wire clk_sys, // 125 MHz system clock
  input wire rst_b, // synchronous reset, active low (pin or power-on)
  input wire scl_in, // main bus clock level
  input wire sda_in, // main bus data level
  output wire sda_out, // data drive value, always low
  output wire sda_oe, // high while pulling data low
  input wire addr_pin_bit0, // address pin 0
  input wire addr_pin_bit1, // address pin 1
  input wire addr_pin_bit2, // address pin 2, mux variant only
  input wire channel0_alert_input, // channel 0 alert, active low
  input wire channel1_alert_input, // channel 1 alert, active low
  input wire channel2_alert_input, // channel 2 alert, active low
  input wire channel3_alert_input, // channel 3 alert, active low
  output wire channel_select_bit0, // applied selection bit 0
  output wire channel_select_bit1, // applied selection bit 1
  output wire channel_select_bit2, // applied selection bit 2
  output wire channel_select_bit3 // applied selection bit 3
);
  // alerts in bits 3:0, address pins in bits 6:4
  localparam PIN_COUNT = 7;
  localparam [PIN_COUNT-1:0] PIN_RESET = `I2CSW_PIN_RESET;
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg scl_reg;
  reg sda_reg;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [3:0] pend_reg;
  reg pend_vld_reg;
  reg [3:0] sel_reg;
  reg sda_oe_reg;
  reg byte_bits_reg; // a bit has been shifted into the byte now being received
  wire [3:0] alert_hi;
  wire [PIN_COUNT-1:0] pin_raw;
  wire [PIN_COUNT-1:0] pin_clean;
  wire [6:0] own_addr;
  wire scl_new;
  wire sda_new;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  // three stage sync; change accepted when stages two and three agree
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
    end
  end

  assign scl_new = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
  assign sda_new = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
  assign scl_rise = scl_new & ~scl_reg;
  assign scl_fall = ~scl_new & scl_reg;
  // data edges while clock stays high
  assign start_det = scl_reg & scl_new & sda_reg & ~sda_new;
  assign stop_det = scl_reg & scl_new & ~sda_reg & sda_new;

  // pins from outside the clock domain, gathered for the synchronisers below
  assign pin_raw = {addr_pin_bit2, addr_pin_bit1, addr_pin_bit0, channel3_alert_input,
    channel2_alert_input, channel1_alert_input, channel0_alert_input};

  // three stage sync per pin; a new level counts once stages two and three agree.
  // alerts reset to their idle high level, so no false alert shows after reset
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
      reg [2:0] pin_sync_reg;
      reg pin_hold_reg;
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          pin_sync_reg <= {3{PIN_RESET[gi]}};
          pin_hold_reg <= PIN_RESET[gi];
        end else begin
          pin_sync_reg <= {pin_sync_reg[1:0], pin_raw[gi]};
          if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_hold_reg <= pin_sync_reg[2];
          end
        end
      end
      assign pin_clean[gi] = pin_hold_reg;
    end
  endgenerate

  // address: fixed prefix plus pin bits
  assign own_addr = (MUX_VARIANT != 0) ?
    {`I2CSW_PREFIX4, pin_clean[6:4]} :
    {`I2CSW_PREFIX5, pin_clean[5:4]};
  // live alert levels, 1 means alert
  assign alert_hi = ~pin_clean[3:0];

  // byte engine; samples on clock rise, drives on clock fall
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= `I2CSW_ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      pend_reg <= `I2CSW_SEL_RESET;
      pend_vld_reg <= 1'b0;
      sel_reg <= `I2CSW_SEL_RESET;
      sda_oe_reg <= 1'b0;
      byte_bits_reg <= 1'b0;
    end else if (start_det) begin
      // restart mid byte aborts; pending byte dropped, selection kept
      state_reg <= `I2CSW_ST_ADDR;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_bits_reg <= 1'b0;
      pend_vld_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= `I2CSW_ST_IDLE;
      sda_oe_reg <= 1'b0;
      byte_bits_reg <= 1'b0;
      pend_vld_reg <= 1'b0;
      if (pend_vld_reg) begin
        sel_reg <= pend_reg;
      end
    end else begin
      case (state_reg)
        `I2CSW_ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        `I2CSW_ST_ADDR, `I2CSW_ST_WDAT: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_bits_reg <= 1'b1;
          end else if (scl_fall && bit_cnt_reg == 3'h0 && byte_bits_reg) begin
            // eight bits in; decide on the falling edge of the eighth pulse.
            // the flag, not the byte value, marks a full byte, so an all-zero
            // control byte is taken and the clock fall right after START is not
            byte_bits_reg <= 1'b0;
            if (state_reg == `I2CSW_ST_ADDR) begin
              if (shift_reg[7:1] == own_addr) begin
                state_reg <= `I2CSW_ST_AACK;
                sda_oe_reg <= 1'b1;
              end else begin
                state_reg <= `I2CSW_ST_IDLE;
              end
            end else begin
              pend_reg <= (MUX_VARIANT != 0) ? {1'b0, shift_reg[2:0]} :
                shift_reg[3:0];
              pend_vld_reg <= 1'b1;
              state_reg <= `I2CSW_ST_WACK;
              sda_oe_reg <= 1'b1;
            end
          end
        end
        `I2CSW_ST_AACK, `I2CSW_ST_WACK: begin
          // release after the ninth pulse; a read drives its first data bit instead
          if (scl_fall) begin
            bit_cnt_reg <= 3'h0;
            if (state_reg == `I2CSW_ST_AACK && shift_reg[0]) begin
              // read: load live alerts and current selection
              shift_reg <= {alert_hi, sel_reg};
              state_reg <= `I2CSW_ST_RDAT;
              sda_oe_reg <= ~(alert_hi[3]);
            end else begin
              shift_reg <= 8'h00;
              state_reg <= `I2CSW_ST_WDAT;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        `I2CSW_ST_RDAT: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= `I2CSW_ST_RACK;
              sda_oe_reg <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
            end
          end
        end
        `I2CSW_ST_RACK: begin
          if (scl_rise) begin
            // master ack asks for another byte, nack ends the read
            if (!sda_reg) begin
              shift_reg <= {alert_hi, sel_reg};
              bit_cnt_reg <= 3'h0;
            end else begin
              state_reg <= `I2CSW_ST_IDLE;
            end
          end else if (scl_fall && bit_cnt_reg == 3'h0) begin
            state_reg <= `I2CSW_ST_RDAT;
            sda_oe_reg <= ~shift_reg[7];
          end
        end
        default: begin
          state_reg <= `I2CSW_ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign channel_select_bit0 = sel_reg[0];
  assign channel_select_bit1 = sel_reg[1];
  assign channel_select_bit2 = sel_reg[2];
  assign channel_select_bit3 = sel_reg[3];
endmodule // i2csw_slave

// >>> sim/i2csw_monitor.sv
// port assertions for the switch control slave
`timescale 1ns/100ps
module i2csw_monitor (
  input wire clk_sys, // clock
  input wire rst_b, // reset, active low
  input wire scl_in, // bus clock
  input wire sda_in, // bus data
  input wire sda_out, // drive value
  input wire sda_oe, // pull enable
  input wire channel_select_bit0, // sel 0
  input wire channel_select_bit1, // sel 1
  input wire channel_select_bit2, // sel 2
  input wire channel_select_bit3 // sel 3
);
  wire [3:0] sel = {channel_select_bit3, channel_select_bit2, channel_select_bit1,
    channel_select_bit0};
  // all checks run on the system clock
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rst_clear_a: assert property (disable iff (1'b0) !rst_b |=> !sda_oe && sel == 4'h0)
    else $error("reset left outputs set");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("drive moved with clock high");
  oe_hold_a: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*8])
    else $error("drive dropped in clock high");
  oe_setup_a: assert property ($rose(sda_oe) |-> !scl_in [*3])
    else $error("drive set too late");
  drive_low_a: assert property (sda_oe |-> !sda_out)
    else $error("drive value not low");
  start_quiet_a: assert property (scl_in && $fell(sda_in) |-> !sda_oe [*8])
    else $error("drive right after start");
  stop_free_a: assert property (scl_in && $rose(sda_in) |-> ##6 !sda_oe)
    else $error("drive after stop");
  sel_at_stop_a: assert property ($changed(sel) |-> scl_in && sda_in)
    else $error("selection moved on busy bus");
endmodule // i2csw_monitor
bind i2csw_slave i2csw_monitor mon (.*);

// >>> sim/i2csw_master.sv
// bus master model for the main two-wire bus
`timescale 1ns/100ps
module i2csw_master (
  output logic scl, // bus clock
  output logic sda_rel, // 0 pulls data low, 1 lets it float high
  input wire logic sda // resolved data line
);
  // both lines rest high while idle
  initial scl = 1'b1;
  initial sda_rel = 1'b1;
  // data falls while clock high
  task start;
    #62.5 sda_rel = 1'b0;
    #62.5 scl = 1'b0;
  endtask
  // data rises while clock high, bus free afterwards
  task stop;
    #31.25 sda_rel = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_rel = 1'b1;
    #62.5;
  endtask
  // n bits msb first; data moves only while the clock is low
  task xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h1FF;
    for (int i = 8; i > 8 - n; i--) begin
      #31.25 sda_rel = tx[i];
      #31.25 scl = 1'b1;
      #31.25 rx[i] = sda;
      #31.25 scl = 1'b0;
    end
  endtask
endmodule // i2csw_master

// >>> sim/i2csw_slave_test.sv
// self-checking bench for the switch control slave
`timescale 1ns/100ps
module i2csw_slave_test;
  logic clk_sys = 1'b0, rst_b = 1'b0, a0 = 1'b0, a1 = 1'b1;
  logic [3:0] alert_n = 4'hF; // active-low alerts
  logic [2:0] mux_pins = 3'h5; // multiplexer address pins, low bits 101
  logic [8:0] rx;
  int num_errors = 0;
  int n_tests = 0;
  wire scl, sda_rel, oe, so, oe2, so2;
  wire [3:0] sel, sel2;
  wire sda = sda_rel & ~oe & ~oe2; // open-drain wired-and
  always #4 clk_sys = ~clk_sys;
  i2csw_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  i2csw_slave #(.MUX_VARIANT(0)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(so), .sda_oe(oe), .addr_pin_bit0(a0), .addr_pin_bit1(a1),
    .addr_pin_bit2(1'b0), .channel0_alert_input(alert_n[0]),
    .channel1_alert_input(alert_n[1]), .channel2_alert_input(alert_n[2]),
    .channel3_alert_input(alert_n[3]), .channel_select_bit0(sel[0]),
    .channel_select_bit1(sel[1]), .channel_select_bit2(sel[2]), .channel_select_bit3(sel[3]));
  // multiplexer variant on the same bus, address 1110101
  i2csw_slave #(.MUX_VARIANT(1)) dut_mux (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(so2), .sda_oe(oe2), .addr_pin_bit0(mux_pins[0]),
    .addr_pin_bit1(mux_pins[1]), .addr_pin_bit2(mux_pins[2]),
    .channel0_alert_input(alert_n[0]), .channel1_alert_input(alert_n[1]),
    .channel2_alert_input(alert_n[2]), .channel3_alert_input(alert_n[3]),
    .channel_select_bit0(sel2[0]), .channel_select_bit1(sel2[1]),
    .channel_select_bit2(sel2[2]), .channel_select_bit3(sel2[3]));
  // compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one byte, master releasing the ninth bit
  task send(input logic [7:0] b, input logic ak);
    m.xfer({b, 1'b1}, 9, rx);
    check(rx[0], ak);
  endtask
  task address(input logic [7:0] b, input logic ak);
    m.start;
    send(b, ak);
  endtask
  task close;
    m.stop;
    repeat (8) @(posedge clk_sys);
  endtask
  // counts and verdict
  task summarize;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    num_errors++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(sel, 8'h00);
    check(sel2, 8'h00);
    // two data bytes, last one applied at stop
    address(8'hE4, 1'b0);
    send(8'hA5, 1'b0);
    send(8'h3C, 1'b0);
    check(sel, 8'h00);
    close;
    check(sel, 8'h0C);
    // read gives live alerts over selection
    alert_n <= 4'hA;
    address(8'hE5, 1'b0);
    m.xfer(9'h1FF, 9, rx);
    check(rx[8:1], 8'h5C);
    close;
    // foreign address is ignored
    address(8'hE6, 1'b1);
    send(8'h0F, 1'b1);
    close;
    a0 <= 1'b1;
    address(8'hE6, 1'b0);
    send(8'h03, 1'b0);
    close;
    check(sel, 8'h03);
    // stop inside a data byte
    address(8'hE6, 1'b0);
    m.xfer(9'h0FF, 4, rx);
    close;
    check(sel, 8'h03);
    // multiplexer keeps the low three bits; switch ignores the foreign address
    address(8'hEA, 1'b0);
    send(8'h0E, 1'b0);
    close;
    check(sel2, 8'h06);
    check(sel, 8'h03);
    address(8'hEB, 1'b0);
    m.xfer(9'h1FF, 9, rx);
    check(rx[8:1], 8'h56);
    close;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(sel, 8'h00);
    check(sel2, 8'h00);
    summarize;
  end
endmodule // i2csw_slave_test
